//--- adc_cal_device.sv
// Purpose: converter control: reset, reference, calibration, scaling
// Assumes: link pins are asynchronous; modulator strobes on clock
// Notes: write frame 16 bits, read frame 33 bits, MSB first
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.

module adc_cal_device (
  // System
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Serial link
  adc_link_if.dev link,
  // Modulator side
  input wire logic [23:0] raw_sample,
  input wire logic raw_valid,
  output logic [1:0] input_sel_q,
  output logic ref_internal_q,
  output logic ext_ref_connect_q,
  output logic supply_mon_q,
  output logic analog_reset_q,
  // Results
  output logic [23:0] data_q,
  output logic rdy_q
);
  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_CONV = 3'b010,
    D_CAL = 3'b100
  } dev_state_t;

  dev_state_t state_q;
  logic [2:0] s1_q, s2_q, s3_q;
  logic rise, fall, cs_lo, din_b;
  logic [5:0] bit_cnt_q, ones_q;
  logic is_read_q, soft_rst_q, clr;
  logic [13:0] shreg_q;
  logic [31:0] tx_q;
  logic dout_q, oe_n_q;
  logic wr_done, rd_done;
  logic [14:0] new_word;
  logic [13:0] cfg_q;
  logic [2:0] mode_q, new_mode, new_gain, cal_cnt_q, need;
  logic [2:0] chan, gain;
  logic new_chop, refused, cal_go, cal_end, err_q;
  logic [23:0] off_q [8];
  logic [23:0] fs_q [8];
  logic [24:0] diff;
  logic [47:0] prod;
  logic [23:0] scaled;

  // Pin synchronisers; third stage only feeds edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= 3'h6;
      s2_q <= 3'h6;
      s3_q <= 3'h6;
    end else if (ce) begin
      s1_q <= {link.sclk, link.cs_n, link.din};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q[2] & ~s3_q[2];
  assign fall = ~s2_q[2] & s3_q[2];
  assign cs_lo = ~s2_q[1];
  assign din_b = s2_q[0];
  assign clr = rst | soft_rst_q;
  assign new_word = {shreg_q, din_b};
  assign new_mode = new_word[adc_cal_pkg::CFG_MODE_LSB +: 3];
  assign new_gain = new_word[adc_cal_pkg::CFG_GAIN_LSB +: 3];
  assign new_chop = new_word[adc_cal_pkg::CFG_CHOP_BIT];
  assign wr_done = rise && cs_lo && !is_read_q
    && bit_cnt_q == 6'(adc_cal_pkg::WR_BITS - 1);
  assign rd_done = rise && cs_lo && is_read_q
    && bit_cnt_q == 6'(adc_cal_pkg::RD_BITS - 1);

  // Run of ones counts across frames; any zero restarts it
  always_ff @(posedge clock) begin
    if (clr) begin
      ones_q <= 6'h00;
      soft_rst_q <= 1'b0;
    end else if (ce) begin
      soft_rst_q <= 1'b0;
      if (rise && cs_lo) begin
        if (!din_b) begin
          ones_q <= 6'h00;
        end else if (ones_q == 6'(adc_cal_pkg::RESET_ONES - 1)) begin
          ones_q <= 6'h00;
          soft_rst_q <= 1'b1;
        end else begin
          ones_q <= ones_q + 6'h01;
        end
      end
    end
  end

  // Modulator and filter restart at power-up and on soft reset
  always_ff @(posedge clock) begin
    if (rst) begin
      analog_reset_q <= 1'b1;
    end else if (ce) begin
      analog_reset_q <= soft_rst_q;
    end
  end

  // Frame bit counter; chip select high ends any frame
  always_ff @(posedge clock) begin
    if (clr) begin
      bit_cnt_q <= 6'h00;
      is_read_q <= 1'b0;
      shreg_q <= 14'h0000;
    end else if (ce) begin
      if (!cs_lo) begin
        bit_cnt_q <= 6'h00;
        is_read_q <= 1'b0;
      end else if (rise) begin
        if (bit_cnt_q == 6'h00) begin
          is_read_q <= din_b;
        end else begin
          shreg_q <= new_word[13:0];
        end
        if (bit_cnt_q != 6'h3f) begin
          bit_cnt_q <= bit_cnt_q + 6'h01;
        end
      end
    end
  end

  // Read frame: status byte then data word, shifted on falling edges
  always_ff @(posedge clock) begin
    if (clr) begin
      tx_q <= 32'h00000000;
    end else if (ce) begin
      if (rise && cs_lo && bit_cnt_q == 6'h00) begin
        tx_q <= {~rdy_q, err_q, 3'h0, chan, data_q};
      end else if (fall && cs_lo && is_read_q) begin
        tx_q <= {tx_q[30:0], 1'b0};
      end
    end
  end

  // Shared pin: data during reads, inverted ready otherwise
  always_ff @(posedge clock) begin
    if (clr) begin
      dout_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else if (ce) begin
      oe_n_q <= ~cs_lo;
      if (!(is_read_q && bit_cnt_q != 6'h00)) begin
        dout_q <= ~rdy_q;
      end else if (fall) begin
        dout_q <= tx_q[31];
      end
    end
  end

  assign link.dout_drv = dout_q;
  assign link.dout_oe_n = oe_n_q;

  // Config bits 13:0: all fields except mode bit 14
  always_ff @(posedge clock) begin
    if (clr) begin
      cfg_q <= adc_cal_pkg::CFG_RESET[13:0] & 14'h0fff;
    end else if (ce && wr_done) begin
      cfg_q <= new_word[13:0];
    end
  end

  assign chan = cfg_q[adc_cal_pkg::CFG_CHAN_LSB +: 3];
  assign gain = cfg_q[adc_cal_pkg::CFG_GAIN_LSB +: 3];

  // Legality and length of the requested calibration
  always_comb begin
    refused = new_mode == adc_cal_pkg::MODE_INT_FULL
      && (new_gain == adc_cal_pkg::GAIN_128
      || (new_gain > adc_cal_pkg::GAIN_4
      && new_word[adc_cal_pkg::CFG_RATE_LSB +: 4]
      < adc_cal_pkg::RATE_SLOW_MIN));
    case (new_mode)
      adc_cal_pkg::MODE_INT_FULL: begin
        if (new_gain == adc_cal_pkg::GAIN_1) begin
          need = new_chop ? adc_cal_pkg::CAL_CYC_G1_CHOP
            : adc_cal_pkg::CAL_CYC_G1_NOCHOP;
        end else begin
          need = new_chop ? adc_cal_pkg::CAL_CYC_HI_CHOP
            : adc_cal_pkg::CAL_CYC_HI_NOCHOP;
        end
      end
      adc_cal_pkg::MODE_SYS_FULL: need = adc_cal_pkg::CAL_CYC_SYS_FULL;
      default: need = adc_cal_pkg::CAL_CYC_ZERO;
    endcase
  end

  assign cal_go = wr_done && new_mode[adc_cal_pkg::MODE_CAL_BIT] && !refused;
  assign cal_end = state_q == D_CAL && raw_valid && cal_cnt_q == 3'h1
    && !wr_done;

  // Mode field; a finished or refused calibration falls back to idle
  always_ff @(posedge clock) begin
    if (clr) begin
      mode_q <= adc_cal_pkg::CFG_RESET[adc_cal_pkg::CFG_MODE_LSB +: 3];
    end else if (ce) begin
      if (wr_done) begin
        mode_q <= refused ? adc_cal_pkg::MODE_IDLE : new_mode;
      end else if (cal_end) begin
        mode_q <= adc_cal_pkg::MODE_IDLE;
      end
    end
  end

  // Sequencer: counts conversion strobes during calibration
  always_ff @(posedge clock) begin
    if (clr) begin
      state_q <= D_CONV;
      cal_cnt_q <= 3'h0;
    end else if (ce) begin
      case (state_q)
        D_IDLE, D_CONV, D_CAL: begin
          if (wr_done) begin
            cal_cnt_q <= need;
            if (cal_go) begin
              state_q <= D_CAL;
            end else if (new_mode == adc_cal_pkg::MODE_CONT && !refused) begin
              state_q <= D_CONV;
            end else begin
              state_q <= D_IDLE;
            end
          end else if (state_q == D_CAL && raw_valid) begin
            cal_cnt_q <= cal_cnt_q - 3'h1;
            if (cal_cnt_q == 3'h1) begin
              state_q <= D_IDLE;
            end
          end
        end
        default: state_q <= D_IDLE;
      endcase
    end
  end

  // Coefficient store, one offset and one full-scale per channel
  for (genvar i = 0; i < 8; i++) begin : g_coef
    always_ff @(posedge clock) begin
      if (clr) begin
        off_q[i] <= adc_cal_pkg::OFF_DEFAULT;
        fs_q[i] <= adc_cal_pkg::FS_DEFAULT;
      end else if (ce && cal_end && chan == 3'(i)) begin
        if (!mode_q[0]) begin
          off_q[i] <= raw_sample;
        end else begin
          fs_q[i] <= raw_sample;
        end
      end
    end
  end

  // Offset first, then gain; negative results clamp to zero
  always_comb begin
    diff = {1'b0, raw_sample} - {1'b0, off_q[chan]};
    prod = diff[23:0] * fs_q[chan];
    if (diff[24]) begin
      scaled = 24'h000000;
    end else if (prod[47]) begin
      scaled = 24'hffffff;
    end else begin
      scaled = prod[adc_cal_pkg::FS_SHIFT +: 24];
    end
  end

  // Data register takes scaled results in continuous mode
  always_ff @(posedge clock) begin
    if (clr) begin
      data_q <= 24'h000000;
    end else if (ce && state_q == D_CONV && raw_valid) begin
      data_q <= scaled;
    end
  end

  // Ready and error flags; a new event wins over the read clear
  always_ff @(posedge clock) begin
    if (clr) begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else if (ce) begin
      if (cal_end || (state_q == D_CONV && raw_valid && !wr_done)) begin
        rdy_q <= 1'b1;
      end else if (cal_go || rd_done) begin
        rdy_q <= 1'b0;
      end
      if (wr_done && refused) begin
        err_q <= 1'b1;
      end else if (rd_done || cal_go) begin
        err_q <= 1'b0;
      end
    end
  end

  // Analog routing follows mode, channel and reference select
  always_ff @(posedge clock) begin
    if (clr) begin
      input_sel_q <= adc_cal_pkg::INSEL_PINS;
      ref_internal_q <= 1'b0;
      ext_ref_connect_q <= 1'b1;
      supply_mon_q <= 1'b0;
    end else if (ce) begin
      supply_mon_q <= chan == adc_cal_pkg::CHAN_SUPPLY;
      ref_internal_q <= cfg_q[adc_cal_pkg::CFG_REFERENCE_SOURCE_SELECT_BIT]
        || chan == adc_cal_pkg::CHAN_SUPPLY;
      ext_ref_connect_q <= !(cfg_q[adc_cal_pkg::CFG_REFERENCE_SOURCE_SELECT_BIT]
        || chan == adc_cal_pkg::CHAN_SUPPLY);
      if (state_q == D_CAL && mode_q == adc_cal_pkg::MODE_INT_ZERO) begin
        input_sel_q <= adc_cal_pkg::INSEL_ZERO;
      end else if (state_q == D_CAL
        && mode_q == adc_cal_pkg::MODE_INT_FULL) begin
        input_sel_q <= adc_cal_pkg::INSEL_FULL;
      end else if (chan == adc_cal_pkg::CHAN_SUPPLY) begin
        input_sel_q <= adc_cal_pkg::INSEL_SUPPLY;
      end else begin
        input_sel_q <= adc_cal_pkg::INSEL_PINS;
      end
    end
  end
endmodule

//--- adc_cal_host.sv
// Purpose: controller driving the converter over the serial link
// Assumes: software commands arrive over Avalon-MM
// Notes: serial clock made here by a divider, idles high
module adc_cal_host #(
  parameter int RESET_WAIT = adc_cal_pkg::RESET_WAIT_CYC
) (
  // System
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata_q,
  output logic waitrequest_q,
  // Serial link
  adc_link_if.host link,
  // System calibration levels and gain tracking
  output logic [1:0] sys_level_q,
  output logic fs_stale_q
);
  typedef enum logic [3:0] {
    H_WAIT = 4'b0001,
    H_IDLE = 4'b0010,
    H_SHIFT = 4'b0100,
    H_POLL = 4'b1000
  } host_state_t;

  host_state_t state_q;
  logic d1_q, d2_q, accept, take, issue, bad;
  logic [14:0] cfg_q;
  logic [2:0] mode, gain, last_gain_q;
  logic [31:0] rdmux;
  logic [32:0] tx_q;
  logic [31:0] rx_q;
  logic [5:0] bits_q;
  logic [3:0] half_q;
  logic [15:0] wait_q;
  logic sclk_q, cs_n_q, din_q, rst_frame_q, rd_frame_q;
  logic refused_q, zero_done_q;
  logic [7:0] stat_q;
  logic [23:0] data_q;

  assign mode = cfg_q[adc_cal_pkg::CFG_MODE_LSB +: 3];
  assign gain = cfg_q[adc_cal_pkg::CFG_GAIN_LSB +: 3];
  assign take = (read || write) && !waitrequest_q;
  assign issue = take && write && address == adc_cal_pkg::REG_COMMAND;
  // Refuse illegal or out-of-order calibrations before sending them
  assign bad = writedata[1:0] == adc_cal_pkg::CMD_WRITE && mode[0]
    && mode[adc_cal_pkg::MODE_CAL_BIT] && (!zero_done_q
    || (mode == adc_cal_pkg::MODE_INT_FULL
    && (gain == adc_cal_pkg::GAIN_128
    || (gain > adc_cal_pkg::GAIN_4
    && cfg_q[adc_cal_pkg::CFG_RATE_LSB +: 4]
    < adc_cal_pkg::RATE_SLOW_MIN))));
  // Command writes stall while the link is busy
  assign accept = (read || write) && waitrequest_q
    && !(write && address == adc_cal_pkg::REG_COMMAND && state_q != H_IDLE);

  always_comb begin
    case (address)
      adc_cal_pkg::REG_CONFIG: rdmux = {17'h00000, cfg_q};
      adc_cal_pkg::REG_STATUS: rdmux = {16'h0000, stat_q, 4'h0,
        zero_done_q, fs_stale_q, refused_q, state_q != H_IDLE};
      adc_cal_pkg::REG_DATA: rdmux = {8'h00, data_q};
      default: rdmux = 32'h00000000;
    endcase
  end

  // Bus answer one cycle after a request is accepted
  always_ff @(posedge clock) begin
    if (rst) begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h00000000;
    end else if (ce) begin
      waitrequest_q <= !accept;
      if (accept) begin
        readdata_q <= rdmux;
      end
    end
  end

  // Software registers and calibration bookkeeping
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q <= adc_cal_pkg::CFG_RESET;
      refused_q <= 1'b0;
      zero_done_q <= 1'b0;
      fs_stale_q <= 1'b0;
      last_gain_q <= adc_cal_pkg::CFG_RESET[adc_cal_pkg::CFG_GAIN_LSB +: 3];
      sys_level_q <= 2'h0;
    end else if (ce) begin
      if (take && write && address == adc_cal_pkg::REG_CONFIG) begin
        cfg_q <= writedata[14:0];
      end
      if (issue && writedata[1:0] == adc_cal_pkg::CMD_WRITE) begin
        refused_q <= bad;
        if (!bad) begin
          last_gain_q <= gain;
          // System level goes out on the edge that starts the mode frame
          sys_level_q <= mode == adc_cal_pkg::MODE_SYS_ZERO ? 2'h1
            : mode == adc_cal_pkg::MODE_SYS_FULL ? 2'h2 : 2'h0;
          if (mode == adc_cal_pkg::MODE_INT_ZERO
            || mode == adc_cal_pkg::MODE_SYS_ZERO) begin
            zero_done_q <= 1'b1;
          end else if (gain != last_gain_q) begin
            zero_done_q <= 1'b0;
          end
          if (mode[adc_cal_pkg::MODE_CAL_BIT] && mode[0]) begin
            fs_stale_q <= 1'b0;
          end else if (gain != last_gain_q) begin
            fs_stale_q <= 1'b1;
          end
        end
      end
    end
  end

  // Data-out/ready line synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      d1_q <= 1'b1;
      d2_q <= 1'b1;
    end else if (ce) begin
      d1_q <= link.dout_pin;
      d2_q <= d1_q;
    end
  end

  // Frame engine: falling edge drives, rising edge samples
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= H_WAIT;
      wait_q <= 16'(RESET_WAIT);
      {sclk_q, cs_n_q, din_q} <= 3'b110;
      tx_q <= 33'h000000000;
      rx_q <= 32'h00000000;
      bits_q <= 6'h00;
      half_q <= 4'h0;
      rst_frame_q <= 1'b0;
      rd_frame_q <= 1'b0;
      stat_q <= 8'h00;
      data_q <= 24'h000000;
    end else if (ce) begin
      case (state_q)
        H_WAIT: begin
          if (wait_q <= 16'h0001) begin
            state_q <= H_IDLE;
          end else begin
            wait_q <= wait_q - 16'h0001;
          end
        end
        H_IDLE: begin
          half_q <= 4'h0;
          if (issue
            && !(writedata[1:0] == adc_cal_pkg::CMD_WRITE && bad)) begin
            cs_n_q <= 1'b0;
            rst_frame_q <= writedata[1:0] == adc_cal_pkg::CMD_RESET;
            rd_frame_q <= writedata[1:0] == adc_cal_pkg::CMD_READ;
            case (writedata[1:0])
              adc_cal_pkg::CMD_WRITE: begin
                tx_q <= {1'b0, cfg_q, 17'h00000};
                bits_q <= 6'(adc_cal_pkg::WR_BITS);
                state_q <= H_SHIFT;
              end
              adc_cal_pkg::CMD_READ: begin
                tx_q <= {1'b1, 32'h00000000};
                bits_q <= 6'(adc_cal_pkg::RD_BITS);
                state_q <= H_SHIFT;
              end
              adc_cal_pkg::CMD_RESET: begin
                tx_q <= {33{1'b1}};
                bits_q <= 6'(adc_cal_pkg::RESET_ONES);
                state_q <= H_SHIFT;
              end
              default: state_q <= H_POLL;
            endcase
          end
        end
        H_SHIFT: begin
          half_q <= half_q + 4'h1;
          if (half_q == 4'(adc_cal_pkg::SCLK_HALF_CYC - 1)) begin
            half_q <= 4'h0;
            if (bits_q == 6'h00) begin
              // Select rises half a period after the last rise, so the
              // converter's synchroniser still sees that rise in frame
              cs_n_q <= 1'b1;
              din_q <= 1'b0;
              if (rst_frame_q) begin
                wait_q <= 16'(RESET_WAIT);
                state_q <= H_WAIT;
              end else begin
                state_q <= H_IDLE;
              end
            end else begin
              sclk_q <= ~sclk_q;
              if (sclk_q) begin
                din_q <= tx_q[32];
                tx_q <= {tx_q[31:0], 1'b0};
              end else begin
                rx_q <= {rx_q[30:0], d2_q};
                bits_q <= bits_q - 6'h01;
                if (bits_q == 6'h01 && rd_frame_q) begin
                  {stat_q, data_q} <= {rx_q[30:0], d2_q};
                end
              end
            end
          end
        end
        H_POLL: begin
          // Give the converter time to drive the line first
          if (half_q != 4'(adc_cal_pkg::SCLK_HALF_CYC - 1)) begin
            half_q <= half_q + 4'h1;
          end else if (!d2_q) begin
            cs_n_q <= 1'b1;
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.din = din_q;
endmodule

//--- adc_cal_pkg.sv
// Purpose: shared constants for the converter control link
// Assumes: 100 MHz system clock on both ends
// Notes: codes here are used by the converter, its controller or both
package adc_cal_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_WAIT_US = 500;
  localparam int RESET_WAIT_CYC =
    (RESET_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 8; // Serial clock half period
  // Frame shapes
  localparam int RESET_ONES = 32;
  localparam int WR_BITS = 16;
  localparam int RD_BITS = 33;
  localparam int CFG_W = 15;
  // Config word fields
  localparam int CFG_MODE_LSB = 12;
  localparam int CFG_CHAN_LSB = 9;
  localparam int CFG_GAIN_LSB = 6;
  localparam int CFG_RATE_LSB = 2;
  localparam int CFG_CHOP_BIT = 1;
  localparam int CFG_REFERENCE_SOURCE_SELECT_BIT = 0;
  localparam logic [14:0] CFG_RESET = 15'h002a;
  // Operating mode codes
  localparam logic [2:0] MODE_CONT = 3'h0;
  localparam logic [2:0] MODE_IDLE = 3'h2;
  localparam logic [2:0] MODE_INT_ZERO = 3'h4;
  localparam logic [2:0] MODE_INT_FULL = 3'h5;
  localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
  localparam logic [2:0] MODE_SYS_FULL = 3'h7;
  localparam int MODE_CAL_BIT = 2;
  // Channel, gain and rate codes
  localparam logic [2:0] CHAN_SUPPLY = 3'h7;
  localparam logic [2:0] GAIN_1 = 3'h0;
  localparam logic [2:0] GAIN_4 = 3'h2;
  localparam logic [2:0] GAIN_128 = 3'h7;
  localparam logic [3:0] RATE_SLOW_MIN = 4'ha; // At or above: 50 Hz or less
  // Calibration lengths in conversion cycles
  localparam logic [2:0] CAL_CYC_ZERO = 3'h2;
  localparam logic [2:0] CAL_CYC_G1_CHOP = 3'h2;
  localparam logic [2:0] CAL_CYC_G1_NOCHOP = 3'h1;
  localparam logic [2:0] CAL_CYC_HI_CHOP = 3'h4;
  localparam logic [2:0] CAL_CYC_HI_NOCHOP = 3'h2;
  localparam logic [2:0] CAL_CYC_SYS_FULL = 3'h2;
  // Coefficients, full scale is 1.0 in 1.23 format
  localparam logic [23:0] OFF_DEFAULT = 24'h000000;
  localparam logic [23:0] FS_DEFAULT = 24'h800000;
  localparam int FS_SHIFT = 23;
  // Converter input select
  localparam logic [1:0] INSEL_PINS = 2'h0;
  localparam logic [1:0] INSEL_ZERO = 2'h1;
  localparam logic [1:0] INSEL_FULL = 2'h2;
  localparam logic [1:0] INSEL_SUPPLY = 2'h3;
  // Controller register map and commands
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_COMMAND = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_DATA = 4'hc;
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_RESET = 2'h2;
  localparam logic [1:0] CMD_WAIT = 2'h3;
endpackage

//--- adc_calibration_reset_control_test.sv
// Purpose: bench for controller and converter across the link
// Assumes: 100 MHz clock, reset wait shortened to 20 cycles
// Notes: software sequences over Avalon-MM, checks at device and controller ports
module adc_calibration_reset_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, read, write, raw_valid, waitrequest_q;
  logic [3:0] address;
  logic [31:0] writedata, readdata_q, rd;
  logic [23:0] raw_sample, data_q;
  logic [1:0] input_sel_q, sys_level_q;
  logic ref_internal_q, ext_ref_connect_q, supply_mon_q;
  logic analog_reset_q, rdy_q, fs_stale_q;
  int bad_count = 0;
  int tests_run = 0;
  adc_link_if adc_link_if_inst ();
  adc_cal_device adc_cal_device_inst (.clock(clock), .rst(rst), .ce(1'b1),
    .link(adc_link_if_inst.dev), .raw_sample(raw_sample),
    .raw_valid(raw_valid), .input_sel_q(input_sel_q),
    .ref_internal_q(ref_internal_q), .ext_ref_connect_q(ext_ref_connect_q),
    .supply_mon_q(supply_mon_q), .analog_reset_q(analog_reset_q),
    .data_q(data_q), .rdy_q(rdy_q));
  adc_cal_host #(.RESET_WAIT(20)) adc_cal_host_inst (.clock(clock),
    .rst(rst), .ce(1'b1), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata_q(readdata_q),
    .waitrequest_q(waitrequest_q), .link(adc_link_if_inst.host),
    .sys_level_q(sys_level_q), .fs_stale_q(fs_stale_q));
  adc_link_chk adc_link_chk_inst (.clock(clock), .rst(rst),
    .sclk(adc_link_if_inst.sclk), .cs_n(adc_link_if_inst.cs_n),
    .din(adc_link_if_inst.din), .dout_drv(adc_link_if_inst.dout_drv),
    .dout_oe_n(adc_link_if_inst.dout_oe_n),
    .dout_pin(adc_link_if_inst.dout_pin));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus cycle; held until waitrequest is seen low
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    int n;
    n = 3000;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clock); while (waitrequest_q !== 1'b0 && --n > 0);
    rd = readdata_q;
    read <= 0;
    write <= 0;
    @(posedge clock);
    if (n == 0) bad_count++;
  endtask
  function automatic logic [31:0] cfg(logic [2:0] m, ch, g, logic c, r);
    return {17'h0, m, ch, g, 4'ha, c, r};
  endfunction
  // Issue one command, poll busy low
  task automatic cmd(logic [1:0] op);
    int n;
    n = 500;
    bus(1, 4'h4, {30'h0, op});
    do bus(0, 4'h8, 32'h0); while (rd[0] !== 1'b0 && --n > 0);
    if (n == 0) bad_count++;
  endtask
  // Write config and send it
  task automatic send(logic [31:0] c);
    bus(1, 4'h0, c);
    cmd(2'h0);
  endtask
  task automatic pulse(logic [23:0] v);
    raw_sample <= v;
    raw_valid <= 1;
    @(posedge clock);
    raw_valid <= 0;
    repeat (3) @(posedge clock);
  endtask
  // Ready must rise on the n-th conversion, not before
  task automatic cal(logic [31:0] c, logic [1:0] sel, int n, logic [23:0] v);
    int k;
    k = 300;
    send(c);
    while (input_sel_q !== sel && --k > 0) @(posedge clock);
    chk("input select", sel, input_sel_q);
    repeat (n - 1) pulse(v);
    chk("ready early", 0, rdy_q);
    // Wait-ready command holds select low until the pin shows ready
    fork
      cmd(2'h3);
      pulse(v);
    join
    chk("ready", 1, rdy_q);
    $display("calibration mode %h done", c[14:12]);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1;
    read = 0;
    write = 0;
    address = 0;
    writedata = 0;
    raw_valid = 0;
    raw_sample = 0;
    repeat (4) @(posedge clock);
    chk("analog reset", 1, analog_reset_q);
    rst <= 0;
    send(cfg(3'h2, 3'h0, 3'h0, 1, 1));
    chk("internal ref", 1, ref_internal_q);
    chk("external ref", 0, ext_ref_connect_q);
    send(cfg(3'h2, 3'h7, 3'h0, 1, 0));
    chk("supply monitor", 1, supply_mon_q);
    chk("supply input", 3, input_sel_q);
    $display("reference tests done");
    cal(cfg(3'h4, 3'h0, 3'h0, 1, 0), 1, 2, 24'h000100);
    cal(cfg(3'h6, 3'h0, 3'h0, 1, 0), 0, 2, 24'h000100);
    chk("system zero level", 1, sys_level_q);
    cal(cfg(3'h5, 3'h0, 3'h0, 1, 0), 2, 2, 24'h400000);
    cal(cfg(3'h5, 3'h0, 3'h0, 0, 0), 2, 1, 24'h400000);
    cal(cfg(3'h4, 3'h0, 3'h2, 1, 0), 1, 2, 24'h000100);
    chk("stale full scale", 1, fs_stale_q);
    cal(cfg(3'h5, 3'h0, 3'h2, 1, 0), 2, 4, 24'h400000);
    chk("fresh full scale", 0, fs_stale_q);
    cal(cfg(3'h7, 3'h0, 3'h2, 1, 0), 0, 2, 24'h400000);
    chk("system full level", 2, sys_level_q);
    send(cfg(3'h0, 3'h0, 3'h2, 1, 0));
    pulse(24'h200100);
    chk("scaled data", 24'h100000, data_q);
    cmd(2'h1);
    bus(0, 4'hc, 32'h0);
    chk("read data", 24'h100000, rd[23:0]);
    chk("ready cleared", 0, rdy_q);
    send(cfg(3'h5, 3'h0, 3'h7, 1, 0));
    chk("refused", 1, rd[1]);
    $display("scaling tests done");
    send(32'h2);
    cmd(2'h2);
    send(cfg(3'h2, 3'h0, 3'h0, 1, 0));
    chk("data after reset", 0, data_q);
    $display("soft reset test done");
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end
endmodule

//--- adc_link_chk.sv
// Purpose: wire checks on the serial link between both ends
// Assumes: one clock domain, sync reset high
// Notes: half period of the serial clock is 8 clocks
module adc_link_chk (
  // System
  input wire logic clock,
  input wire logic rst,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_drv,
  input wire logic dout_oe_n,
  input wire logic dout_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Framing shape; sclk must never idle low or glitch
  a_sclk_idle_high: assert property (cs_n |-> sclk)
    else $error("serial clock low outside a frame");
  a_cs_moves_high: assert property ($changed(cs_n) |-> sclk)
    else $error("chip select moved while clock low");
  a_frame_lead_in: assert property ($fell(cs_n) |-> sclk[*8])
    else $error("first clock fall too early");
  a_low_half: assert property ($fell(sclk) |-> !sclk[*8])
    else $error("clock low half not 8 cycles");
  a_din_held_high: assert property (
    sclk && $past(sclk) && !cs_n && $past(!cs_n) |-> $stable(din))
    else $error("data changed while clock high");
  // Shared pin: released while deselected, reads high then
  a_oe_off_idle: assert property (cs_n[*8] |-> dout_oe_n)
    else $error("pin driven while deselected");
  a_oe_on_select: assert property ($fell(dout_oe_n) |-> !cs_n)
    else $error("pin enabled without chip select");
  a_pin_resolve: assert property (
    dout_pin == (dout_oe_n ? 1'b1 : dout_drv))
    else $error("pin level does not match drive");
  // Reset holds both ends quiet; checked through reset itself
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> cs_n && sclk && dout_oe_n)
    else $error("link not idle after reset");
  c_frame: cover property ($fell(cs_n));
  c_one_bit: cover property ($rose(sclk) && !cs_n && din);
  c_pin_low: cover property ($fell(dout_pin) && !cs_n);
endmodule

//--- adc_link_if.sv
// Purpose: four-wire serial link between controller and converter
// Assumes: data-out/ready line is pulled high when released
// Notes: resolves the shared pin from the converter's enable
interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_drv;
  logic dout_oe_n;
  logic dout_pin;

  // Released line reads high
  assign dout_pin = dout_oe_n ? 1'b1 : dout_drv;

  modport dev(input sclk, input cs_n, input din,
    output dout_drv, output dout_oe_n);
  modport host(output sclk, output cs_n, output din, input dout_pin);
endinterface
